// ===== core/fsp_device.sv
// device end: sector lock, pointer region and protection mode commands
//
module fsp_device
    import fsp_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    fsp_link_if.dev                   link,
    input  wire logic                 protect_scheme_select_i,
    input  wire logic                 addr_wide_i,
    input  wire logic                 qpi_i,
    input  wire logic [PM_W-1:0]      protect_mode_register_i,
    input  wire logic                 suspended_i,
    input  wire logic                 op_fail_i,
    input  wire logic                 clear_error_i,
    output logic [N_SECTORS-1:0]      sector_lock_bit_o,
    output logic                      write_in_progress_o,
    output logic                      write_enable_latch_o,
    output logic                      nonvolatile_lock_bit_o,
    output logic                      program_error_o,
    output logic [31:0]               pointer_region_o
);
    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_OPC  = 3'h1,
        D_ADR  = 3'h3,
        D_CMP  = 3'h2,
        D_DUM  = 3'h5,
        D_DATA = 3'h7,
        D_IGN  = 3'h6
    } fsp_dstate_t;

    fsp_dstate_t          st;
    logic [5:0]           sync1;
    logic [5:0]           sync2;
    logic                 sck_q;
    logic                 cs_q;
    logic [5:0]           cnt;
    logic [31:0]          sr;
    logic [7:0]           op;
    logic [15:0]          out_sh;
    logic [3:0]           io_o;
    logic [3:0]           io_oe;
    logic [N_SECTORS-1:0] lock;
    logic                 write_in_progress;
    logic                 write_enable_latch;
    logic                 nonvolatile_lock_bit;
    logic                 perr;
    logic [31:0]          ptr;
    logic [BUSY_W-1:0]    busy;
    logic [7:0]           pend;
    logic [SEC_W-1:0]     psec;
    logic [31:0]          paddr;

    // pins cross into clk_i through two flops; only sync2 is read
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1 <= 6'h20;
            sync2 <= 6'h20;
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            sync1 <= {link.cs_n, link.sck, link.io};
            sync2 <= sync1;
            sck_q <= sync2[4];
            cs_q  <= sync2[5];
        end
    end

    wire logic       sck_s = sync2[4];
    wire logic       cs_s  = sync2[5];
    wire logic [3:0] io_s  = sync2[3:0];
    wire logic rise  = sck_s & ~sck_q & ~cs_s;
    wire logic fall  = ~sck_s & sck_q & ~cs_s;
    wire logic cs_up = cs_s & ~cs_q;
    wire logic cs_dn = ~cs_s & cs_q;

    wire logic [31:0] shift_in = qpi_i ? {sr[27:0], io_s}
                                       : {sr[30:0], io_s[0]};
    wire logic [7:0]  op_now   = shift_in[7:0];
    wire logic [5:0]  cnt_inc  = cnt + 6'h01;
    wire logic [5:0]  opc_need = qpi_i ? (OPC_BITS >> 2) : OPC_BITS;
    wire logic [5:0]  adr_bits = fsp_addr_bits(op, addr_wide_i);
    wire logic [5:0]  adr_need = qpi_i ? (adr_bits >> 2) : adr_bits;
    wire logic        opc_done = cnt_inc == opc_need;
    wire logic        adr_done = cnt_inc == adr_need;
    wire logic        op_is_rd = op inside {OP_LOCK_RD, OP_LOCK_RD_W};

    // the lock register reads all ones when unprotected, zeros when locked
    wire logic [SEC_W-1:0] rd_sec    = shift_in[SEC_LSB +: SEC_W];
    wire logic [15:0]      lock_word = {16{lock[rd_sec]}};
    wire logic [15:0]      mode_word = {protect_mode_register_i[7:0],
                                        protect_mode_register_i[15:8]};

    // command gates, decided when the opcode completes
    wire logic pm_pwr  = protect_mode_register_i[PM_PWR_BIT];
    wire logic pm_pwd  = protect_mode_register_i[PM_PWD_BIT];
    wire logic ptr_ok  = ~suspended_i & nonvolatile_lock_bit & pm_pwr
                       & ~(~pm_pwd & ~nonvolatile_lock_bit) & write_enable_latch;
    wire logic is_ptr  = op_now inside {OP_PTR, OP_PTR_W};
    wire logic is_rdop = op_now inside {OP_LOCK_RD, OP_LOCK_RD_W,
                                        OP_MODE_RD};
    wire logic known   = fsp_has_addr(op_now) | (op_now inside
                         {OP_GLOCK, OP_GUNLOCK, OP_MODE_RD, OP_WRITE_ENABLE_CMD,
                          OP_PRL});
    wire logic accept  = known
                       & (~fsp_lock_family(op_now)
                          | protect_scheme_select_i)
                       & (is_rdop | ~write_in_progress)
                       & (~is_ptr | ptr_ok)
                       & ((op_now != OP_PRL) | write_enable_latch);
    wire fsp_dstate_t after_opc = ~accept ? D_IGN
                               : fsp_has_addr(op_now) ? D_ADR
                               : (op_now == OP_MODE_RD) ? D_DUM
                               : D_CMP;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st  <= D_IDLE;
            cnt <= 6'h00;
            sr  <= 32'h0000_0000;
            op  <= 8'h00;
        end else if (cs_up) begin
            st <= D_IDLE;
        end else if (cs_dn) begin
            st  <= D_OPC;
            cnt <= 6'h00;
        end else if (rise) begin
            sr  <= shift_in;
            cnt <= cnt_inc;
            unique case (st)
                D_OPC: begin
                    if (opc_done) begin
                        op  <= op_now;
                        cnt <= 6'h00;
                        st  <= after_opc;
                    end
                end
                D_ADR: begin
                    if (adr_done) begin
                        st <= op_is_rd ? D_DATA : D_CMP;
                    end
                end
                D_DUM:  st <= D_DATA;
                D_CMP:  st <= D_IGN;
                D_IDLE, D_DATA, D_IGN: st <= st;
                default: st <= D_IGN;
            endcase
        end
    end

    // read data: loaded at the last address or dummy edge, rotated on fall
    wire logic load_lock = rise & (st == D_ADR) & adr_done & op_is_rd;
    wire logic load_mode = rise & (st == D_DUM);
    wire logic [15:0] rot = qpi_i ? {out_sh[11:0], out_sh[15:12]}
                                  : {out_sh[14:0], out_sh[15]};

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_sh <= 16'h0000;
            io_o   <= 4'h0;
            io_oe  <= 4'h0;
        end else if (cs_up) begin
            io_oe <= 4'h0;
        end else if (load_lock) begin
            out_sh <= lock_word;
        end else if (load_mode) begin
            out_sh <= mode_word;
        end else if (fall && st == D_DATA) begin
            io_oe  <= qpi_i ? 4'hF : 4'h2;
            io_o   <= qpi_i ? out_sh[15:12] : {2'h0, out_sh[15], 1'h0};
            out_sh <= rot;
        end
    end

    // self-timed operations start only from a complete frame
    wire logic go   = cs_up & (st == D_CMP);
    wire logic fin  = write_in_progress & (busy == BUSY_LAST);
    wire logic p_pt = pend inside {OP_PTR, OP_PTR_W};
    wire logic p_lk = pend inside {OP_LOCK, OP_LOCK_W};
    wire logic p_ul = pend inside {OP_UNLOCK, OP_UNLOCK_W};
    wire logic wide = fsp_wide_op(op) | addr_wide_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            write_in_progress   <= 1'b0;
            busy  <= 8'h00;
            pend  <= 8'h00;
            psec  <= 4'h0;
            paddr <= 32'h0000_0000;
        end else if (go && op != OP_WRITE_ENABLE_CMD) begin
            write_in_progress   <= 1'b1;
            busy  <= OP_COUNT;
            pend  <= op;
            psec  <= sr[SEC_LSB +: SEC_W];
            paddr <= wide ? sr : {8'h00, sr[23:0]};
        end else if (write_in_progress) begin
            busy <= busy - BUSY_LAST;
            write_in_progress  <= ~fin;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            write_enable_latch    <= 1'b0;
            nonvolatile_lock_bit <= NONVOLATILE_LOCK_BIT_RST;
            ptr    <= 32'h0000_0000;
            perr   <= 1'b0;
        end else begin
            if (go && op == OP_WRITE_ENABLE_CMD) begin
                write_enable_latch <= 1'b1;
            end else if (fin && (p_pt || pend == OP_PRL)) begin
                write_enable_latch <= 1'b0;
            end
            if (fin && pend == OP_PRL) begin
                nonvolatile_lock_bit <= 1'b0;
            end
            if (fin && p_pt && !op_fail_i) begin
                ptr <= paddr;
            end
            // a failure in the same cycle as a clear still sticks
            if (fin && p_pt && op_fail_i) begin
                perr <= 1'b1;
            end else if (clear_error_i) begin
                perr <= 1'b0;
            end
        end
    end

    for (genvar g = 0; g < N_SECTORS; g++) begin : g_lock
        wire logic hit = psec == SEC_W'(g);
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                lock[g] <= LOCK_RST;
            end else if (fin) begin
                if (pend == OP_GLOCK || (p_lk && hit)) begin
                    lock[g] <= 1'b0;
                end else if (pend == OP_GUNLOCK || (p_ul && hit)) begin
                    lock[g] <= 1'b1;
                end
            end
        end
    end

    assign link.dev_io_o          = io_o;
    assign link.dev_io_oe         = io_oe;
    assign sector_lock_bit_o      = lock;
    assign write_in_progress_o    = write_in_progress;
    assign write_enable_latch_o   = write_enable_latch;
    assign nonvolatile_lock_bit_o = nonvolatile_lock_bit;
    assign program_error_o        = perr;
    assign pointer_region_o       = ptr;
endmodule : fsp_device

// ===== core/fsp_pkg.sv
// shared constants and decode helpers for the sector protection link
package fsp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int OP_TIME_NS    = 2000;
    localparam int OP_CYCLES     =
        (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_NS   = 80;
    localparam int SCK_HALF_CYC  = SCK_HALF_NS / CLK_PERIOD_NS;
    localparam int BUSY_W        = 8;
    localparam logic [BUSY_W-1:0] OP_COUNT = BUSY_W'(OP_CYCLES);
    localparam logic [BUSY_W-1:0] BUSY_LAST = 8'h01;
    localparam logic [3:0] DIV_LAST = 4'(SCK_HALF_CYC - 1);

    localparam int N_SECTORS = 16;
    localparam int SEC_W     = 4;
    localparam int SEC_LSB   = 12;
    localparam int PM_W      = 16;
    localparam int PM_PWR_BIT = 1;
    localparam int PM_PWD_BIT = 2;
    localparam logic LOCK_RST   = 1'b1;
    localparam logic NONVOLATILE_LOCK_BIT_RST = 1'b1;
    localparam logic [5:0] ADDR_BITS_N = 6'h18;
    localparam logic [5:0] ADDR_BITS_W = 6'h20;
    localparam logic [5:0] OPC_BITS    = 6'h08;

    localparam logic [7:0] OP_LOCK_RD   = 8'h3D;
    localparam logic [7:0] OP_LOCK_RD_W = 8'hE0;
    localparam logic [7:0] OP_LOCK      = 8'h36;
    localparam logic [7:0] OP_LOCK_W    = 8'hE1;
    localparam logic [7:0] OP_UNLOCK    = 8'h39;
    localparam logic [7:0] OP_UNLOCK_W  = 8'hE2;
    localparam logic [7:0] OP_GLOCK     = 8'h7E;
    localparam logic [7:0] OP_GUNLOCK   = 8'h98;
    localparam logic [7:0] OP_PTR       = 8'hFB;
    localparam logic [7:0] OP_PTR_W     = 8'hE3;
    localparam logic [7:0] OP_MODE_RD   = 8'h2B;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h06;
    localparam logic [7:0] OP_PRL       = 8'hA6;

    function automatic logic fsp_wide_op(input logic [7:0] op);
        return op inside {OP_LOCK_RD_W, OP_LOCK_W, OP_UNLOCK_W, OP_PTR_W};
    endfunction : fsp_wide_op

    function automatic logic fsp_has_addr(input logic [7:0] op);
        return op inside {OP_LOCK_RD, OP_LOCK_RD_W, OP_LOCK, OP_LOCK_W,
                          OP_UNLOCK, OP_UNLOCK_W, OP_PTR, OP_PTR_W};
    endfunction : fsp_has_addr

    function automatic logic fsp_lock_family(input logic [7:0] op);
        return op inside {OP_LOCK_RD, OP_LOCK_RD_W, OP_LOCK, OP_LOCK_W,
                          OP_UNLOCK, OP_UNLOCK_W, OP_GLOCK, OP_GUNLOCK};
    endfunction : fsp_lock_family

    function automatic logic [5:0] fsp_addr_bits(input logic [7:0] op,
                                                 input logic cfg_wide);
        return (fsp_wide_op(op) | cfg_wide) ? ADDR_BITS_W : ADDR_BITS_N;
    endfunction : fsp_addr_bits
endpackage : fsp_pkg

// ===== core/fsp_link_if.sv
// serial link between controller and device, wire levels resolved here
interface fsp_link_if;
    logic       cs_n;
    logic       sck;
    logic [3:0] host_io_o;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_o;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // undriven lines float high through the board pull-ups
    assign io = (host_io_oe & host_io_o) | (dev_io_oe & dev_io_o)
              | ~(host_io_oe | dev_io_oe);

    modport host (output cs_n, output sck, output host_io_o,
                  output host_io_oe, input io);
    modport dev  (input cs_n, input sck, input io,
                  output dev_io_o, output dev_io_oe);
endinterface : fsp_link_if

// ===== core/fsp_host.sv
// controller end: frames one command per request on the serial link
module fsp_host
    import fsp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    fsp_link_if.host         link,
    input  wire logic        qpi_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_op_i,
    input  wire logic [31:0] cmd_addr_i,
    input  wire logic        cmd_addr_wide_i,
    input  wire logic [1:0]  cmd_rd_bytes_i,
    output logic             cmd_ready_o,
    output logic             done_o,
    output logic [15:0]      rd_data_o
);
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_SEL  = 3'h1,
        H_RUN  = 3'h3,
        H_TAIL = 3'h2,
        H_GAP  = 3'h6
    } fsp_hstate_t;

    fsp_hstate_t st;
    logic [3:0]  sync1;
    logic [3:0]  io_s;
    logic [3:0]  div;
    logic        cs_n;
    logic        sck;
    logic [3:0]  io_o;
    logic [3:0]  io_oe;
    logic [39:0] tx;
    logic [15:0] rx;
    logic [6:0]  e;
    logic [6:0]  n_tx;
    logic [6:0]  n_pre;
    logic [6:0]  n_all;
    logic        ready;
    logic        done;
    logic [15:0] rd_data;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1 <= 4'hF;
            io_s  <= 4'hF;
        end else begin
            sync1 <= link.io;
            io_s  <= sync1;
        end
    end

    // the serial clock comes from a divider on clk_i
    wire logic tick = (st != H_IDLE) && (div == DIV_LAST);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || st == H_IDLE || tick) begin
            div <= 4'h0;
        end else begin
            div <= div + 4'h1;
        end
    end

    // frame lengths in serial clock rises
    wire logic [5:0] ab = fsp_has_addr(cmd_op_i)
                        ? fsp_addr_bits(cmd_op_i, cmd_addr_wide_i) : 6'h00;
    wire logic [6:0] tx_bits = 7'(OPC_BITS) + 7'(ab);
    wire logic [6:0] tx_e    = qpi_i ? (tx_bits >> 2) : tx_bits;
    wire logic [6:0] dum_e   = (cmd_op_i == OP_MODE_RD) ? 7'h01 : 7'h00;
    wire logic [6:0] rx_bits = {2'h0, cmd_rd_bytes_i, 3'h0};
    wire logic [6:0] rx_e    = qpi_i ? (rx_bits >> 2) : rx_bits;
    wire logic [31:0] a_al   = (ab == ADDR_BITS_W) ? cmd_addr_i
                             : {cmd_addr_i[23:0], 8'h00};
    wire logic [39:0] tx_nx  = qpi_i ? {tx[35:0], 4'h0}
                                     : {tx[38:0], 1'h0};
    wire logic [3:0]  out_nx = qpi_i ? tx_nx[39:36] : {3'h0, tx_nx[39]};
    wire logic [15:0] rx_nx  = qpi_i ? {rx[11:0], io_s}
                                     : {rx[14:0], io_s[1]};
    wire logic start = (st == H_IDLE) & cmd_valid_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st    <= H_IDLE;
            cs_n  <= 1'b1;
            sck   <= 1'b0;
            io_o  <= 4'h0;
            io_oe <= 4'h0;
            tx    <= 40'h00_0000_0000;
            rx    <= 16'h0000;
            e     <= 7'h00;
            n_tx  <= 7'h00;
            n_pre <= 7'h00;
            n_all <= 7'h00;
        end else if (start) begin
            st    <= H_SEL;
            cs_n  <= 1'b0;
            tx    <= {cmd_op_i, a_al};
            io_o  <= qpi_i ? cmd_op_i[7:4] : {3'h0, cmd_op_i[7]};
            io_oe <= qpi_i ? 4'hF : 4'h1;
            e     <= 7'h00;
            n_tx  <= tx_e;
            n_pre <= tx_e + dum_e;
            n_all <= tx_e + dum_e + rx_e;
        end else if (tick) begin
            unique case (st)
                H_SEL: st <= H_RUN;
                H_RUN: begin
                    sck <= ~sck;
                    if (!sck) begin
                        e <= e + 7'h01;
                        if (e >= n_pre) begin
                            rx <= rx_nx;
                        end
                    end else begin
                        tx   <= tx_nx;
                        io_o <= out_nx;
                        // lines released for dummy and read phases
                        if (e >= n_tx) begin
                            io_oe <= 4'h0;
                        end
                        if (e == n_all) begin
                            st <= H_TAIL;
                        end
                    end
                end
                H_TAIL: begin
                    cs_n <= 1'b1;  // deselect one half period after the last clock fall
                    st   <= H_GAP;
                end
                H_GAP: st <= H_IDLE;
                H_IDLE: st <= H_IDLE;
                default: st <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ready   <= 1'b1;
            done    <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            done <= tick && st == H_GAP;
            if (start) begin
                ready <= 1'b0;
            end else if (tick && st == H_GAP) begin
                ready   <= 1'b1;
                rd_data <= rx;
            end
        end
    end

    assign link.cs_n       = cs_n;
    assign link.sck        = sck;
    assign link.host_io_o  = io_o;
    assign link.host_io_oe = io_oe;
    assign cmd_ready_o     = ready;
    assign done_o          = done;
    assign rd_data_o       = rd_data;
endmodule : fsp_host

// ===== dv/fsp_link_sva.sv
// link checker for the sector protection serial interface
module fsp_link_sva (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic [3:0] host_io_o,
    input  wire logic [3:0] host_io_oe,
    input  wire logic [3:0] dev_io_o,
    input  wire logic [3:0] dev_io_oe,
    input  wire logic [3:0] io
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // one high half of the serial clock, then the fall
    sequence s_high_half;
        sck [*8] ##1 !sck;
    endsequence
    // select seen high long enough for the device to settle
    sequence s_quiet;
        cs_n [*6];
    endsequence
    sequence s_gap;
        cs_n [*8];
    endsequence

    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock high outside a frame");
    a_half_period: assert property ($rose(sck) |-> s_high_half)
        else $error("serial clock high half not eight cycles");
    a_low_at_start: assert property ($fell(cs_n) |-> (!sck) [*7])
        else $error("serial clock rose too soon after select");
    a_host_hold: assert property (
        (sck && $past(sck) && host_io_oe != 4'h0) |-> $stable(host_io_o))
        else $error("host data moved while clock high");
    a_dev_shift_low: assert property (
        (dev_io_oe != 4'h0 && $past(dev_io_oe) != 4'h0
         && $changed(dev_io_o)) |-> !sck)
        else $error("device data moved while clock high");
    a_no_fight: assert property ((host_io_oe & dev_io_oe) == 4'h0)
        else $error("both ends drive the data lines");
    a_dev_lanes: assert property (
        dev_io_oe inside {4'h0, 4'h2, 4'hF})
        else $error("device drives an odd set of lines");
    a_dev_quiet: assert property (s_quiet |-> dev_io_oe == 4'h0)
        else $error("device drives lines while deselected");
    a_select_gap: assert property ($rose(cs_n) |-> s_gap)
        else $error("select high for under eight cycles");
    a_host_off: assert property (cs_n |-> host_io_oe == 4'h0)
        else $error("host drives lines while deselected");
endmodule : fsp_link_sva

// ===== dv/flash_sector_protect_commands_bench.sv
// self-checking bench joining controller and device over the link
module flash_sector_protect_commands_bench
    import fsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        scheme = 1'b1;
    logic        wide = 1'b0;
    logic        quad_peripheral_mode = 1'b0;
    logic [15:0] pm = 16'h0000;
    logic        susp = 1'b0;
    logic        fail = 1'b0;
    logic        clr = 1'b0;
    logic        valid = 1'b0;
    logic [7:0]  op = 8'h00;
    logic [31:0] addr = 32'h0;
    logic [1:0]  rdn = 2'h0;
    logic [15:0] lock;
    logic        write_in_progress;
    logic        write_enable_latch;
    logic        nvl;
    logic        perr;
    logic [31:0] ptr;
    logic        ready;
    logic        done;
    logic [15:0] rdat;
    logic        sck_q = 1'b0;
    logic        cs_q = 1'b1;
    int          nrise = 0;
    int          cyc = 0;
    int          num_errors = 0;
    int          samples_checked = 0;

    fsp_link_if fsp_link_if_i ();
    fsp_host fsp_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .link(fsp_link_if_i), .qpi_i(quad_peripheral_mode), .cmd_valid_i(valid),
        .cmd_op_i(op), .cmd_addr_i(addr), .cmd_addr_wide_i(wide),
        .cmd_rd_bytes_i(rdn), .cmd_ready_o(ready), .done_o(done),
        .rd_data_o(rdat));
    fsp_device fsp_device_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .link(fsp_link_if_i), .protect_scheme_select_i(scheme),
        .addr_wide_i(wide), .qpi_i(quad_peripheral_mode), .protect_mode_register_i(pm),
        .suspended_i(susp), .op_fail_i(fail), .clear_error_i(clr),
        .sector_lock_bit_o(lock), .write_in_progress_o(write_in_progress),
        .write_enable_latch_o(write_enable_latch), .nonvolatile_lock_bit_o(nvl),
        .program_error_o(perr), .pointer_region_o(ptr));
    fsp_link_sva fsp_link_sva_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cs_n(fsp_link_if_i.cs_n), .sck(fsp_link_if_i.sck),
        .host_io_o(fsp_link_if_i.host_io_o),
        .host_io_oe(fsp_link_if_i.host_io_oe),
        .dev_io_o(fsp_link_if_i.dev_io_o),
        .dev_io_oe(fsp_link_if_i.dev_io_oe), .io(fsp_link_if_i.io));

    always #5 clk_i = ~clk_i;

    // counts clock rises per frame straight off the wire
    always @(posedge clk_i) begin
        sck_q <= fsp_link_if_i.sck;
        cs_q <= fsp_link_if_i.cs_n;
        if (fsp_link_if_i.sck && !sck_q) nrise <= nrise + 1;
        if (cs_q && !fsp_link_if_i.cs_n) nrise <= 0;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one command; t set when a self-timed operation must follow
    task automatic send(input logic [7:0] o, input logic [31:0] a,
                        input logic [1:0] n, input logic t);
        int k;
        @(posedge clk_i);
        op <= o;
        addr <= a;
        rdn <= n;
        valid <= 1'b1;
        @(posedge clk_i);
        valid <= 1'b0;
        for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk_i);
        chk(32'(done), 32'h1);
        chk(32'(ready), 32'h1);
        if (t) chk(32'(write_in_progress), 32'h1);
        for (k = 0; k < 400 && write_in_progress !== 1'b0; k++) @(posedge clk_i);
        chk(32'(write_in_progress), 32'h0);
    endtask : send

    task automatic t_sector();
        chk(32'(lock), 32'hFFFF);
        send(OP_LOCK, 32'h3000, 2'h0, 1'b1);
        chk(32'(lock), 32'hFFF7);
        chk(32'(nrise), 32'd32);
        send(OP_LOCK_RD, 32'h3000, 2'h2, 1'b0);
        chk(32'(rdat), 32'h0000);
        send(OP_LOCK_RD_W, 32'h4000, 2'h2, 1'b0);
        chk(32'(rdat), 32'hFFFF);
        chk(32'(nrise), 32'd56);
        wide <= 1'b1;
        send(OP_UNLOCK, 32'h3000, 2'h0, 1'b1);
        chk(32'(lock), 32'hFFFF);
        chk(32'(nrise), 32'd40);
        wide <= 1'b0;
        send(OP_LOCK_W, 32'h9000, 2'h0, 1'b1);
        chk(32'(lock), 32'hFDFF);
        send(OP_UNLOCK_W, 32'h9000, 2'h0, 1'b1);
        chk(32'(lock), 32'hFFFF);
        // quad frames carry the address on all four lines
        quad_peripheral_mode <= 1'b1;
        send(OP_LOCK, 32'h5000, 2'h0, 1'b1);
        chk(32'(lock), 32'hFFDF);
        chk(32'(nrise), 32'd8);
        send(OP_LOCK_RD, 32'h5000, 2'h2, 1'b0);
        chk(32'(rdat), 32'h0000);
        send(OP_UNLOCK, 32'h5000, 2'h0, 1'b1);
        chk(32'(lock), 32'hFFFF);
        quad_peripheral_mode <= 1'b0;
    endtask : t_sector

    task automatic t_global();
        for (int q = 0; q < 2; q++) begin
            quad_peripheral_mode <= q[0];
            send(OP_GLOCK, 32'h0, 2'h0, 1'b1);
            chk(32'(lock), 32'h0000);
            chk(32'(nrise), q ? 32'd2 : 32'd8);
            send(OP_GUNLOCK, 32'h0, 2'h0, 1'b1);
            chk(32'(lock), 32'hFFFF);
        end
        quad_peripheral_mode <= 1'b0;
        // extra clock rises after the opcode cancel the global lock
        send(OP_GLOCK, 32'h0, 2'h1, 1'b0);
        chk(32'(lock), 32'hFFFF);
        // scheme off: the lock write must leave every bit alone
        scheme <= 1'b0;
        send(OP_GLOCK, 32'h0, 2'h0, 1'b0);
        chk(32'(lock), 32'hFFFF);
        scheme <= 1'b1;
    endtask : t_global

    task automatic t_mode();
        pm <= 16'hA5C3;
        for (int q = 0; q < 2; q++) begin
            quad_peripheral_mode <= q[0];
            send(OP_MODE_RD, 32'h0, 2'h2, 1'b0);
            chk(32'(rdat), 32'hC3A5);
            // 24 bits: the last 16 are low byte again after the high one
            send(OP_MODE_RD, 32'h0, 2'h3, 1'b0);
            chk(32'(rdat), 32'hA5C3);
        end
        quad_peripheral_mode <= 1'b0;
    endtask : t_mode

    task automatic t_ptr();
        pm <= 16'h0006;
        chk(32'(nvl), 32'h1);
        send(OP_PTR, 32'h12000, 2'h0, 1'b0);
        chk(ptr, 32'h0);
        send(OP_WRITE_ENABLE_CMD, 32'h0, 2'h0, 1'b0);
        chk(32'(write_enable_latch), 32'h1);
        send(OP_PTR, 32'h12000, 2'h0, 1'b1);
        chk(ptr, 32'h12000);
        chk(32'(write_enable_latch), 32'h0);
        send(OP_WRITE_ENABLE_CMD, 32'h0, 2'h0, 1'b0);
        fail <= 1'b1;
        send(OP_PTR_W, 32'h0003_4000, 2'h0, 1'b1);
        chk(32'(perr), 32'h1);
        fail <= 1'b0;
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        @(posedge clk_i);
        chk(32'(perr), 32'h0);
        send(OP_WRITE_ENABLE_CMD, 32'h0, 2'h0, 1'b0);
        susp <= 1'b1;
        send(OP_PTR, 32'h56000, 2'h0, 1'b0);
        chk(ptr, 32'h12000);
        susp <= 1'b0;
        pm <= 16'h0004;
        send(OP_PTR, 32'h56000, 2'h0, 1'b0);
        chk(ptr, 32'h12000);
        send(OP_PRL, 32'h0, 2'h0, 1'b1);
        chk(32'(nvl), 32'h0);
        send(OP_WRITE_ENABLE_CMD, 32'h0, 2'h0, 1'b0);
        pm <= 16'h0006;
        send(OP_PTR, 32'h56000, 2'h0, 1'b0);
        chk(ptr, 32'h12000);
    endtask : t_ptr

    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_sector();
        t_global();
        t_mode();
        t_ptr();
        wrap_up();
    end
endmodule : flash_sector_protect_commands_bench
